// File: logic/adc_ctrl_regs.vh
// Register offsets, field positions and reset values of the converter control
// block. Definitions only; included by the control module.
`ifndef ADC_CTRL_REGS_VH
`define ADC_CTRL_REGS_VH

`define OFS_CTRLA      8'h00
`define OFS_CTRLB      8'h04
`define OFS_CTRLC      8'h08
`define OFS_CTRLD      8'h0c
`define OFS_CTRLE      8'h10
`define OFS_SAMPCTRL   8'h14
`define OFS_POSITIVE_INPUT_SELECT     8'h18
`define OFS_COMMAND    8'h20
`define OFS_EVCTRL     8'h24
`define OFS_INTEN      8'h28
`define OFS_INTERRUPT_FLAG_REGISTER   8'h2c
`define OFS_CALIB      8'h30
`define OFS_RESULT     8'h40
`define OFS_WINLOW     8'h48
`define OFS_WINHIGH    8'h50

`define CTRLA_ENABLE   0
`define CTRLA_FREERUN  1
`define CTRLA_RESSEL   2
`define CTRLA_RUNSTBY  7
`define CTRLC_PRESC_LO 0
`define CTRLC_REF_LO   4
`define CTRLC_CAP      6
`define CTRLD_DLY_LO   5
`define FLAG_RESULT_READY_FLAG    0
`define FLAG_WINDOW    1

`define REFERENCE_SELECT_INTERNAL 2'h0
`define MUX_TEMPSENSE   5'h1e
`define CONV_CYCLES     5'h0d
`define SH_CYCLE        5'h02
`define FULL_SCALE      11'h3ff

`define WIN_NONE    3'h0
`define WIN_BELOW   3'h1
`define WIN_ABOVE   3'h2
`define WIN_INSIDE  3'h3
`define WIN_OUTSIDE 3'h4

`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`define RESET_VALUE 8'h00

`endif

// File: logic/adc_result_window_sleep_ctrl.v
// Converter control: registers on AXI4-Lite, conversion sequencing, result
// accumulation, window compare, result-ready event and sleep behaviour.
// Assumes an analog core that gives a 10-bit code each conversion on
// i_sample_code when told to sample; all inputs synchronous to i_clk.
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "adc_ctrl_regs.vh"

// Overview of operation
// - Result equals 1023 times vin over vref
// - Temperature channel selection powers the sensor
// - Calibration gain and offset bytes readable
// - Window below, above, inside, outside conditions
// - Compare only while mode code nonzero
// - Compare once after last accumulated sample
// - Touch controller owns converter when enabled
// - Event starts conversion when enabled
// - One-cycle result-ready event on every result
// - Interrupt while flag and enable set
// - Standby stops converter unless run-in-standby
// - Standby starts by event or free-run
// - Event edge sets start bit, completion clears it except in free-run
// - Initial delay holds off first conversion
// - Power-down freezes conversion, result invalid
// - Start bit reads one while converting
// - Flag clears on result read or write-one
module adc_result_window_sleep_ctrl #(
    parameter [7:0] TEMP_GAIN_CAL   = 8'h80, // Arbitrary default
    parameter [7:0] TEMP_OFFSET_CAL = 8'h00  // Arbitrary default
) (
    input  wire        i_clk,
    input  wire        i_srst,
    input  wire [7:0]  i_awaddr,
    input  wire        i_awvalid,
    output wire        o_awready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    input  wire        i_wvalid,
    output wire        o_wready,
    output reg  [1:0]  o_bresp,
    output reg         o_bvalid,
    input  wire        i_bready,
    input  wire [7:0]  i_araddr,
    input  wire        i_arvalid,
    output wire        o_arready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    output reg         o_rvalid,
    input  wire        i_rready,
    input  wire        i_event_trigger,
    input  wire        i_touch_controller_enable,
    input  wire        i_standby_sleep,
    input  wire        i_powerdown_sleep,
    input  wire [9:0]  i_sample_code,
    output reg         o_sample_strobe,
    output wire [4:0]  o_positive_input_select,
    output wire [1:0]  o_reference_select,
    output wire        o_reduced_sample_capacitance,
    output wire        o_temp_sensor_enable,
    output wire        o_result_ready_event,
    output wire        o_irq,
    output wire        o_clock_request
);

    localparam [3:0] S_IDLE = 4'h1;
    localparam [3:0] S_DLY  = 4'h2;
    localparam [3:0] S_CONV = 4'h4;
    localparam [3:0] S_DONE = 4'h8;

    reg  [7:0]  ctrla;
    reg  [2:0]  sample_number;
    reg  [7:0]  ctrlc;
    reg  [7:0]  ctrld;
    reg  [2:0]  window_mode_code;
    reg  [4:0]  sample_length;
    reg  [4:0]  positive_input_select;
    reg         start_conversion;
    reg         start_on_event_enable;
    reg  [1:0]  interrupt_enable_register;
    reg         result_ready_flag;
    reg         window_compare_flag;
    reg  [15:0] conversion_result;
    reg  [15:0] window_low_threshold;
    reg  [15:0] window_high_threshold;
    reg  [15:0] accum;
    reg  [6:0]  acc_count;
    reg  [3:0]  state;
    reg  [7:0]  div_cnt;
    reg  [9:0]  step_cnt;
    reg         first_done;
    reg         event_prev;
    reg         ready_pulse;
    reg  [7:0]  aw_addr;
    reg         aw_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg         w_held;

    // Converter accessible only to software when touch controller is off
    wire enabled   = ctrla[`CTRLA_ENABLE] & ~i_touch_controller_enable;
    wire sleep_off = i_standby_sleep & ~ctrla[`CTRLA_RUNSTBY];
    wire active    = enabled & ~sleep_off;
    wire frozen    = i_powerdown_sleep;
    wire [7:0] presc_factor =
        8'h02 << ctrlc[`CTRLC_PRESC_LO +: 3];
    wire adc_tick  = (div_cnt == presc_factor - 8'h01) & ~frozen;
    wire event_rise = i_event_trigger & ~event_prev;
    wire [6:0] acc_target = 7'h01 << sample_number;
    wire [2:0] init_dly = ctrld[`CTRLD_DLY_LO +: 3];
    wire [9:0] dly_cycles = (init_dly == 3'h0) ? 10'h000 :
                            (10'h008 << (init_dly - 3'h1));
    wire [3:0] samp_dly = ctrld[3:0];
    wire [7:0] conv_len = {3'h0, `CONV_CYCLES} + {3'h0, samp_dly[3:0] ,1'b0}
                          - {4'h0, samp_dly[3:0]} + {3'h0, sample_length};
    wire [9:0] code = ctrla[`CTRLA_RESSEL] ? {2'h0, i_sample_code[9:2]}
                                           : i_sample_code;
    wire [15:0] acc_next = accum + {6'h0, code};
    wire write_go = aw_held & w_held & ~o_bvalid;
    wire read_go  = i_arvalid & ~o_rvalid;

    // Unsigned strict compares for every window condition
    function window_hit;
        input [2:0]  mode;
        input [15:0] val;
        input [15:0] lo;
        input [15:0] hi;
        begin
            case (mode)
                `WIN_BELOW:   window_hit = val < lo;
                `WIN_ABOVE:   window_hit = val > hi;
                `WIN_INSIDE:  window_hit = (val > lo) & (val < hi);
                `WIN_OUTSIDE: window_hit = (val < lo) | (val > hi);
                default:      window_hit = 1'b0;
            endcase
        end
    endfunction

    function [7:0] wr_byte;
        input [7:0] old;
        begin
            wr_byte = w_strb[0] ? w_data[7:0] : old;
        end
    endfunction

    assign o_awready = ~aw_held;
    assign o_wready  = ~w_held;
    assign o_arready = ~o_rvalid;
    assign o_positive_input_select = positive_input_select;
    assign o_reference_select = ctrlc[`CTRLC_REF_LO +: 2];
    assign o_reduced_sample_capacitance = ctrlc[`CTRLC_CAP];
    assign o_temp_sensor_enable =
        enabled & (positive_input_select == `MUX_TEMPSENSE);
    assign o_result_ready_event = ready_pulse;
    assign o_irq = (result_ready_flag & interrupt_enable_register[0]) |
                   (window_compare_flag & interrupt_enable_register[1]);
    assign o_clock_request = active & (state != S_IDLE);

    wire done_now = (state == S_DONE);
    wire res_read = read_go & (i_araddr == `OFS_RESULT);

    always @(posedge i_clk) begin
        if (i_srst) begin
            ctrla <= `RESET_VALUE;
            sample_number <= 3'h0;
            ctrlc <= `RESET_VALUE;
            ctrld <= `RESET_VALUE;
            window_mode_code <= `WIN_NONE;
            sample_length <= 5'h00;
            positive_input_select <= 5'h00;
            start_on_event_enable <= 1'b0;
            interrupt_enable_register <= 2'h0;
            window_low_threshold <= 16'h0000;
            window_high_threshold <= 16'h0000;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= `RESP_OKAY;
            o_rvalid <= 1'b0;
            o_rresp <= `RESP_OKAY;
            o_rdata <= 32'h0000_0000;
        end else begin
            if (i_awvalid & ~aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= i_awaddr;
            end
            if (i_wvalid & ~w_held) begin
                w_held <= 1'b1;
                w_data <= i_wdata;
                w_strb <= i_wstrb;
            end
            if (o_bvalid & i_bready)
                o_bvalid <= 1'b0;
            if (write_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= `RESP_OKAY;
                case (aw_addr)
                    `OFS_CTRLA:    ctrla <= wr_byte(ctrla) & 8'h87;
                    `OFS_CTRLB:    if (w_strb[0])
                                       sample_number <= w_data[2:0];
                    `OFS_CTRLC:    ctrlc <= wr_byte(ctrlc) & 8'h77;
                    `OFS_CTRLD:    ctrld <= wr_byte(ctrld) & 8'hef;
                    `OFS_CTRLE:    if (w_strb[0])
                                       window_mode_code <= w_data[2:0];
                    `OFS_SAMPCTRL: if (w_strb[0])
                                       sample_length <= w_data[4:0];
                    `OFS_POSITIVE_INPUT_SELECT:   if (w_strb[0])
                                       positive_input_select <= w_data[4:0];
                    `OFS_EVCTRL:   if (w_strb[0])
                                       start_on_event_enable <= w_data[0];
                    `OFS_INTEN:    if (w_strb[0])
                                       interrupt_enable_register <=
                                           w_data[1:0];
                    `OFS_WINLOW: begin
                        if (w_strb[0]) window_low_threshold[7:0] <=
                                           w_data[7:0];
                        if (w_strb[1]) window_low_threshold[15:8] <=
                                           w_data[15:8];
                    end
                    `OFS_WINHIGH: begin
                        if (w_strb[0]) window_high_threshold[7:0] <=
                                           w_data[7:0];
                        if (w_strb[1]) window_high_threshold[15:8] <=
                                           w_data[15:8];
                    end
                    `OFS_COMMAND, `OFS_INTERRUPT_FLAG_REGISTER: ;
                    default: o_bresp <= `RESP_SLVERR;
                endcase
            end
            if (o_rvalid & i_rready)
                o_rvalid <= 1'b0;
            if (read_go) begin
                o_rvalid <= 1'b1;
                o_rresp <= `RESP_OKAY;
                o_rdata <= 32'h0000_0000;
                case (i_araddr)
                    `OFS_CTRLA:    o_rdata[7:0] <= ctrla;
                    `OFS_CTRLB:    o_rdata[2:0] <= sample_number;
                    `OFS_CTRLC:    o_rdata[7:0] <= ctrlc;
                    `OFS_CTRLD:    o_rdata[7:0] <= ctrld;
                    `OFS_CTRLE:    o_rdata[2:0] <= window_mode_code;
                    `OFS_SAMPCTRL: o_rdata[4:0] <= sample_length;
                    `OFS_POSITIVE_INPUT_SELECT:   o_rdata[4:0] <= positive_input_select;
                    `OFS_COMMAND:  o_rdata[0] <= start_conversion;
                    `OFS_EVCTRL:   o_rdata[0] <= start_on_event_enable;
                    `OFS_INTEN:    o_rdata[1:0] <= interrupt_enable_register;
                    `OFS_INTERRUPT_FLAG_REGISTER: o_rdata[1:0] <=
                                       {window_compare_flag,
                                        result_ready_flag};
                    `OFS_CALIB:    o_rdata[15:0] <=
                                       {TEMP_OFFSET_CAL, TEMP_GAIN_CAL};
                    `OFS_RESULT:   o_rdata[15:0] <= conversion_result;
                    `OFS_WINLOW:   o_rdata[15:0] <= window_low_threshold;
                    `OFS_WINHIGH:  o_rdata[15:0] <= window_high_threshold;
                    default:       o_rresp <= `RESP_SLVERR;
                endcase
            end
        end
    end

    wire sw_start = write_go & (aw_addr == `OFS_COMMAND) & w_strb[0] &
                    w_data[0];
    wire flag_wr  = write_go & (aw_addr == `OFS_INTERRUPT_FLAG_REGISTER) & w_strb[0];
    wire win_hit  = done_now & (window_mode_code != `WIN_NONE) &
                    window_hit(window_mode_code, acc_next,
                               window_low_threshold,
                               window_high_threshold);
    // Standby allows only event or an already running free-run start
    wire ev_start = start_on_event_enable & event_rise;
    wire any_start = ev_start | (sw_start & ~i_standby_sleep);

    always @(posedge i_clk) begin
        if (i_srst) begin
            state <= S_IDLE;
            start_conversion <= 1'b0;
            div_cnt <= 8'h00;
            step_cnt <= 10'h000;
            accum <= 16'h0000;
            acc_count <= 7'h00;
            conversion_result <= 16'h0000;
            result_ready_flag <= 1'b0;
            window_compare_flag <= 1'b0;
            first_done <= 1'b0;
            event_prev <= 1'b0;
            ready_pulse <= 1'b0;
            o_sample_strobe <= 1'b0;
        end else begin
            event_prev <= i_event_trigger;
            ready_pulse <= 1'b0;
            o_sample_strobe <= 1'b0;
            // Set wins over clear so a completing result is never lost
            if (flag_wr & w_data[`FLAG_RESULT_READY_FLAG] | res_read)
                result_ready_flag <= 1'b0;
            if (flag_wr & w_data[`FLAG_WINDOW])
                window_compare_flag <= 1'b0;
            if (state == S_IDLE || ~active)
                div_cnt <= 8'h00;
            else if (~frozen)
                div_cnt <= adc_tick ? 8'h00 : div_cnt + 8'h01;
            if (~active) begin
                state <= S_IDLE;
                start_conversion <= 1'b0;
                first_done <= 1'b0;
            end else begin
                case (state)
                    S_IDLE: if (any_start & ~frozen) begin
                        start_conversion <= 1'b1;
                        acc_count <= 7'h00;
                        accum <= 16'h0000;
                        step_cnt <= 10'h000;
                        state <= (first_done | dly_cycles == 10'h000) ?
                                 S_CONV : S_DLY;
                    end
                    S_DLY: if (adc_tick) begin
                        step_cnt <= step_cnt + 10'h001;
                        if (step_cnt == dly_cycles - 10'h001) begin
                            step_cnt <= 10'h000;
                            state <= S_CONV;
                        end
                    end
                    S_CONV: if (adc_tick) begin
                        step_cnt <= step_cnt + 10'h001;
                        if (step_cnt == {5'h00, `SH_CYCLE})
                            o_sample_strobe <= 1'b1;
                        if (step_cnt == {2'h0, conv_len} - 10'h001) begin
                            step_cnt <= 10'h000;
                            if (acc_count == acc_target - 7'h01)
                                state <= S_DONE;
                            else begin
                                accum <= acc_next;
                                acc_count <= acc_count + 7'h01;
                            end
                        end
                    end
                    S_DONE: begin
                        conversion_result <= acc_next;
                        result_ready_flag <= 1'b1;
                        ready_pulse <= 1'b1;
                        first_done <= 1'b1;
                        accum <= 16'h0000;
                        acc_count <= 7'h00;
                        if (ctrla[`CTRLA_FREERUN]) begin
                            state <= S_CONV;
                        end else begin
                            state <= S_IDLE;
                            start_conversion <= 1'b0;
                        end
                    end
                    default: state <= S_IDLE;
                endcase
            end
            if (win_hit)
                window_compare_flag <= 1'b1;
        end
    end

endmodule

// File: verification/adc_ctrl_chk.sv
// Port checker for the converter control block.
// Bound to the block's top module; one clock, synchronous reset.
`timescale 1ns/100ps
module adc_ctrl_chk (
    input logic       i_clk,
    input logic       i_srst,
    input logic       i_awvalid,
    input logic       i_wvalid,
    input logic       i_arvalid,
    input logic       i_touch_controller_enable,
    input logic       i_powerdown_sleep,
    input logic       o_sample_strobe,
    input logic [4:0] o_positive_input_select,
    input logic       o_temp_sensor_enable,
    input logic       o_result_ready_event,
    input logic       o_irq,
    input logic       o_clock_request
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    logic [7:0] n_strb;
    logic [2:0] bus_age;
    // Flags only move through the bus or a result, so track bus recency
    always @(posedge i_clk) begin
        if (i_srst || i_touch_controller_enable || o_result_ready_event)
            n_strb <= {7'h0, o_sample_strobe};
        else if (o_sample_strobe)
            n_strb <= n_strb + 8'h1;
        if (i_srst || i_awvalid || i_wvalid || i_arvalid)
            bus_age <= 3'h0;
        else if (bus_age != 3'h7)
            bus_age <= bus_age + 3'h1;
    end
    sequence result_out;
        ##[0:2] o_result_ready_event;
    endsequence
    event_pulse_a:
    assert property (o_result_ready_event |=> !o_result_ready_event)
        else $error("result event longer than one cycle");
    accum_count_a:
    assert property (o_result_ready_event |-> $onehot(n_strb))
        else $error("sample count per result not a power of two");
    touch_idle_a:
    assert property (i_touch_controller_enable [*2] |->
        !o_sample_strobe && !o_result_ready_event)
        else $error("converter active while owned by touch");
    powerdown_hold_a:
    assert property (i_powerdown_sleep [*3] |->
        !o_sample_strobe && !o_result_ready_event)
        else $error("converter active in power-down");
    strobe_clock_a:
    assert property (o_sample_strobe |-> o_clock_request)
        else $error("sampling without clock request");
    clock_release_a:
    assert property ($fell(o_clock_request) && !i_touch_controller_enable
        |-> result_out)
        else $error("clock released without a result");
    irq_rise_a:
    assert property ($rose(o_irq) |-> o_result_ready_event || bus_age < 3'h4)
        else $error("interrupt rose without cause");
    irq_hold_a:
    assert property ($fell(o_irq) |-> bus_age < 3'h4)
        else $error("interrupt dropped without a clear");
    temp_sensor_a:
    assert property (o_temp_sensor_enable |-> o_positive_input_select == 5'h1e)
        else $error("sensor on for another channel");
endmodule

// File: verification/adc_result_window_sleep_ctrl_tb.sv
// Bench for the converter control block: bus, conversions, window,
// event start, touch ownership and sleep modes.
// Assumes the analog and event stand-in and the port checker.
`timescale 1ns/100ps
module adc_result_window_sleep_ctrl_tb;
    logic        i_clk   = 1'b0;
    logic        i_srst  = 1'b1;
    logic [7:0]  awaddr  = 8'h00;
    logic [7:0]  araddr  = 8'h00;
    logic [31:0] wdata   = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        arvalid = 1'b0;
    logic        bready  = 1'b0;
    logic        rready  = 1'b0;
    logic [3:0]  wstrb   = 4'hf;
    logic        touch   = 1'b0;
    logic        stby    = 1'b0;
    logic        pdown   = 1'b0;
    logic [9:0]  level   = 10'h000;
    logic [31:0] d;
    logic [1:0]  r;
    logic [9:0]  lvl [5] = '{10'h080, 10'h100, 10'h200, 10'h300, 10'h3ff};
    wire  [31:0] rdata;
    wire  [9:0]  code;
    wire  [4:0]  psel;
    wire  [1:0]  rresp, bresp, rsel;
    wire         awready, wready, bvalid, arready, rvalid, trig;
    wire         strobe, cap, tsen, evt, irq, creq;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          seed = 48154;
    int          n_evt = 0;
    int          t0, base, i, m;

    adc_result_window_sleep_ctrl #(
        .TEMP_GAIN_CAL  (8'h5a), // Arbitrary
        .TEMP_OFFSET_CAL(8'ha7)  // Arbitrary
    ) i_dut (
        .i_clk(i_clk), .i_srst(i_srst), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready), .i_event_trigger(trig),
        .i_touch_controller_enable(touch), .i_standby_sleep(stby),
        .i_powerdown_sleep(pdown), .i_sample_code(code),
        .o_sample_strobe(strobe), .o_positive_input_select(psel),
        .o_reference_select(rsel), .o_reduced_sample_capacitance(cap),
        .o_temp_sensor_enable(tsen), .o_result_ready_event(evt),
        .o_irq(irq), .o_clock_request(creq));
    analog_event_model i_model (.i_clk(i_clk), .i_strobe(strobe),
        .i_level(level), .o_code(code), .o_trigger(trig));

    always #10 i_clk = ~i_clk;
    always @(posedge i_clk) if (evt) n_evt <= n_evt + 1;

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            num_checks++;
            if (seen !== exp) begin
                n_mismatch++;
                $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        begin
            awaddr  <= a;
            wdata   <= v;
            awvalid <= 1'b1;
            wvalid  <= 1'b1;
            do begin
                @(posedge i_clk);
                if (awready && awvalid) awvalid <= 1'b0;
                if (wready && wvalid) wvalid <= 1'b0;
                bready <= !bvalid;
            end while (!bvalid);
            r = bresp;
        end
    endtask
    task rd(input logic [7:0] a);
        begin
            araddr  <= a;
            arvalid <= 1'b1;
            do begin
                @(posedge i_clk);
                if (arready) arvalid <= 1'b0;
                rready <= !rvalid;
            end while (!rvalid);
            d = rdata;
            r = rresp;
        end
    endtask
    task wait_evt;
        int e;
        begin
            e = n_evt;
            t0 = 0;
            while (n_evt == e) begin
                @(posedge i_clk);
                t0++;
            end
        end
    endtask
    task nothing(input int n);
        int e;
        begin
            e = n_evt;
            repeat (n) @(posedge i_clk);
            chk(n_evt, e);
        end
    endtask
    // Strict compares: a value on a threshold never matches
    function logic winf(input int md, input logic [15:0] v);
        case (md)
            1: return v < 16'h100;
            2: return v > 16'h300;
            3: return v > 16'h100 && v < 16'h300;
            4: return v < 16'h100 || v > 16'h300;
            default: return 1'b0;
        endcase
    endfunction
    task final_report;
        begin
            $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
            if (n_mismatch == 0 && num_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    initial begin
        #(20 * 40000);
        n_mismatch++;
        final_report;
    end
    initial begin
        repeat (10) @(posedge i_clk);
        i_srst <= 1'b0;
        rd(8'h30);
        chk(d, 32'ha75a);
        rd(8'h7c);
        chk(r, 2'h2);
        chk(d, 32'h0);
        wr(8'h7c, 32'h0);
        chk(r, 2'h2);
        for (i = 0; i < 6; i++) begin
            level <= 10'($random(seed));
            wr(8'h00, {29'h0, i[0], 2'h1});
            wr(8'h20, 32'h1);
            rd(8'h20);
            chk(d[0], 1'b1);
            wait_evt;
            rd(8'h2c);
            chk(d[0], 1'b1);
            rd(8'h20);
            chk(d[0], 1'b0);
            rd(8'h40);
            chk(d, i[0] ? level >> 2 : level);
            rd(8'h2c);
            chk(d[0], 1'b0);
        end
        wr(8'h00, 32'h1);
        wr(8'h20, 32'h1);
        wait_evt;
        wr(8'h2c, 32'h1);
        rd(8'h2c);
        chk(d[0], 1'b0);
        wstrb <= 4'h1;
        wr(8'h48, 32'hbeef);
        chk(r, 2'h0);
        wstrb <= 4'hf;
        rd(8'h48);
        chk(d, 32'h00ef);
        wr(8'h48, 32'h100);
        wr(8'h50, 32'h300);
        wr(8'h28, 32'h2);
        for (m = 0; m < 5; m++)
            for (i = 0; i < 5; i++) begin
                level <= lvl[i];
                wr(8'h10, m);
                wr(8'h20, 32'h1);
                wait_evt;
                rd(8'h2c);
                chk(d[1], winf(m, lvl[i]));
                chk(irq, winf(m, lvl[i]));
                wr(8'h2c, 32'h3);
            end
        // The first two partial sums fall inside, the final sum does not
        wr(8'h04, 32'h2);
        wr(8'h48, 32'h0);
        wr(8'h50, 32'h600);
        wr(8'h10, 32'h3);
        level <= 10'h2c1;
        wr(8'h20, 32'h1);
        wait_evt;
        nothing(80);
        rd(8'h2c);
        chk(d[1:0], 2'h1);
        chk(irq, 1'b0);
        rd(8'h40);
        chk(d, 32'hb04);
        wr(8'h04, 32'h0);
        wr(8'h10, 32'h0);
        wr(8'h24, 32'h1);
        i_model.fire(3);
        rd(8'h20);
        chk(d[0], 1'b1);
        wait_evt;
        rd(8'h2c);
        chk(d[0], 1'b1);
        rd(8'h20);
        chk(d[0], 1'b0);
        wr(8'h24, 32'h0);
        i_model.fire(3);
        nothing(150);
        touch <= 1'b1;
        wr(8'h20, 32'h1);
        nothing(100);
        touch <= 1'b0;
        repeat (100) @(posedge i_clk);
        wr(8'h2c, 32'h3);
        stby <= 1'b1;
        wr(8'h24, 32'h1);
        i_model.fire(3);
        nothing(150);
        wr(8'h00, 32'h81);
        i_model.fire(3);
        chk(creq, 1'b1);
        wait_evt;
        repeat (3) @(posedge i_clk);
        chk(creq, 1'b0);
        wr(8'h20, 32'h1);
        nothing(150);
        stby <= 1'b0;
        wr(8'h2c, 32'h3);
        wr(8'h20, 32'h1);
        wait_evt;
        base = t0;
        wr(8'h0c, 32'h20);
        // Re-enable so that this start counts as the first one
        wr(8'h00, 32'h0);
        wr(8'h00, 32'h1);
        wr(8'h20, 32'h1);
        wait_evt;
        chk(t0 - base, 16);
        wr(8'h0c, 32'h0);
        wr(8'h2c, 32'h3);
        wr(8'h20, 32'h1);
        repeat (6) @(posedge i_clk);
        pdown <= 1'b1;
        nothing(50);
        pdown <= 1'b0;
        wait_evt;
        chk(t0 + 56, base + 50);
        rd(8'h2c);
        chk(d[0], 1'b1);
        wr(8'h18, 32'h1e);
        wr(8'h08, 32'h40);
        chk(tsen, 1'b1);
        chk({psel, rsel, cap}, {5'h1e, 2'h0, 1'b1});
        wr(8'h18, 32'h3);
        chk(tsen, 1'b0);
        final_report;
    end
endmodule

bind adc_result_window_sleep_ctrl adc_ctrl_chk i_chk (
    .i_clk(i_clk), .i_srst(i_srst), .i_awvalid(i_awvalid),
    .i_wvalid(i_wvalid), .i_arvalid(i_arvalid),
    .i_touch_controller_enable(i_touch_controller_enable),
    .i_powerdown_sleep(i_powerdown_sleep), .o_sample_strobe(o_sample_strobe),
    .o_positive_input_select(o_positive_input_select),
    .o_temp_sensor_enable(o_temp_sensor_enable),
    .o_result_ready_event(o_result_ready_event), .o_irq(o_irq),
    .o_clock_request(o_clock_request));

// File: verification/analog_event_model.sv
// Far-side stand-in: the sampled analog input and the event trigger.
// Assumes the bench sets the input level before each conversion.
`timescale 1ns/100ps
module analog_event_model (
    input  wire       i_clk,
    input  wire       i_strobe,
    input  wire [9:0] i_level,
    output reg  [9:0] o_code,
    output reg        o_trigger
);
    initial begin
        o_code    = 10'h000;
        o_trigger = 1'b0;
    end
    // The held sample stays put until the next sample-and-hold step
    always @(posedge i_clk)
        if (i_strobe)
            o_code <= i_level;
    task fire(input int hi);
        begin
            @(posedge i_clk);
            o_trigger <= 1'b1;
            repeat (hi) @(posedge i_clk);
            o_trigger <= 1'b0;
        end
    endtask
endmodule
